//--- common/link_cfg_pkg.sv
// Purpose: shared constants and types for the control-channel bridge settings block
// Assumes: 20 MHz core clock, 8-bit register path from the local register access logic
// Notes: aliases of the remote targets live elsewhere and arrive as inputs
package link_cfg_pkg;
   // register offsets
   localparam logic [7:0] OFS_CHAN_CTRL = 8'h06;
   localparam logic [7:0] OFS_FAR_ADDR = 8'h07;
   localparam logic [7:0] OFS_TGT_MAP0 = 8'h08;
   localparam logic [7:0] OFS_TGT_MAP1 = 8'h09;
   localparam logic [7:0] RST_ALL = 8'h00;
   // channel control fields
   localparam int BIT_SEQ_ERR = 7;
   localparam int BIT_SEQ_CLR = 6;
   localparam int BIT_DLY_HI = 4;
   localparam int BIT_DLY_LO = 3;
   localparam int BIT_WR_LOCK = 2;
   localparam int BIT_IDLE_FAST = 1;
   localparam int BIT_WD_OFF = 0;
   // address registers
   localparam int BIT_ADDR_HI = 7;
   localparam int BIT_ADDR_LO = 1;
   localparam int BIT_ADDR_HOLD = 0;
   // timing
   localparam int CLK_NS = 50;
   localparam int SDA_BASE_NS = 250;
   localparam int SDA_STEP_NS = 50;
   localparam int SDA_BASE_CYC = SDA_BASE_NS / CLK_NS;
   localparam int SDA_STEP_CYC = SDA_STEP_NS / CLK_NS;
   localparam int SDA_MAX_CYC = SDA_BASE_CYC + 3 * SDA_STEP_CYC;
   localparam int WD_FAST_NS = 50000;
   localparam int WD_FAST_CYC = WD_FAST_NS / CLK_NS;
   localparam int WD_SLOW_MS = 1000;
   localparam int WD_SLOW_CYC = WD_SLOW_MS * (1000000 / CLK_NS);
   localparam int SCL_HALF_NS = 5000;
   localparam int SCL_HALF_CYC = SCL_HALF_NS / CLK_NS;
   localparam int RECOVER_PULSES = 9;
   localparam int WD_CNT_W = 25;

   typedef enum logic [1:0] {WD_IDLE, WD_LOW, WD_HIGH} wd_state_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic remote;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic valid;
      logic [6:0] addr;
   } i2c_fwd_t;

   typedef struct packed {
      logic seq_err;
      logic seq_clr;
      logic [1:0] sda_dly;
      logic wr_lock;
      logic idle_fast;
      logic wd_off;
      logic [6:0] far_addr;
      logic far_hold;
      logic [6:0] phys0;
      logic [6:0] phys1;
      logic [7:0] rdata;
      logic ack;
      wd_state_t wst;
      logic [WD_CNT_W-1:0] cnt;
      logic [3:0] pulses;
      logic scl_oe;
      logic bus_free;
      logic scl_q;
      logic sda_q;
      i2c_fwd_t fwd;
      logic tgt_grant;
      logic pin_lvl;
   } cfg_state_t;
endpackage : link_cfg_pkg

//--- logic/sda_out_delay.sv
// Purpose: delays the SDA pull-down request by a selectable number of cycles
// Assumes: dly_i between 1 and MAX_DLY
// Notes: output comes straight from a flip-flop
`timescale 1ns/1ns
module sda_out_delay #(
   parameter int MAX_DLY = link_cfg_pkg::SDA_MAX_CYC
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   // control
   input wire logic [3:0] dly_i,
   input wire logic drive_i,
   // delayed pin enable
   output logic drive_o
);
   typedef struct packed {
      logic [MAX_DLY-1:0] sr;
      logic out;
   } dly_state_t;

   dly_state_t st_r;
   dly_state_t st_nxt;

   function automatic int tap(input logic [3:0] d);
      if (d == 4'h0) begin
         return 0;
      end else if (int'(d) > MAX_DLY) begin
         return MAX_DLY - 1;
      end else begin
         return int'(d) - 1;
      end
   endfunction : tap

   always_comb begin
      st_nxt = st_r;
      st_nxt.sr = {st_r.sr[MAX_DLY-2:0], drive_i};
      st_nxt.out = st_r.sr[tap(dly_i)];
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_r <= '0;
      end else if (ce_i) begin
         st_r <= st_nxt;
      end
   end

   assign drive_o = st_r.out;
endmodule : sda_out_delay

//--- logic/ctrl_channel_i2c_bridge_cfg.sv
// Purpose: control-channel bridge settings: sequence error flag, SDA delay, write lock,
//          bus watchdog with recovery, far serializer address and two target remaps
// Assumes: all inputs synchronous to clock_i; register requests come from the device's
//          own register access logic, remote ones flagged by reg_req_i.remote
// Notes: register answers one cycle after the request
`timescale 1ns/1ns
module ctrl_channel_i2c_bridge_cfg #(
   parameter int WD_SLOW_CYCLES = link_cfg_pkg::WD_SLOW_CYC,
   parameter int WD_FAST_CYCLES = link_cfg_pkg::WD_FAST_CYC,
   parameter int SCL_HALF_CYCLES = link_cfg_pkg::SCL_HALF_CYC
) (
   // clock, reset, enable
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   // register access
   input wire link_cfg_pkg::reg_req_t reg_req_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_ack_o,
   // forward channel status
   input wire logic seq_err_i,
   input wire logic rx_lock_i,
   input wire logic far_id_valid_i,
   input wire logic [6:0] far_id_i,
   // local bus pins
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic sda_drive_i,
   output logic bus_free_o,
   // pass-through decode
   input wire logic pass_en_i,
   input wire logic [6:0] alias0_i,
   input wire logic [6:0] alias1_i,
   input wire logic fwd_req_i,
   input wire logic [6:0] fwd_addr_i,
   output link_cfg_pkg::i2c_fwd_t fwd_o,
   // remote access to local targets
   input wire logic rmt_tgt_req_i,
   output logic rmt_tgt_grant_o
);
   link_cfg_pkg::cfg_state_t st_r;
   link_cfg_pkg::cfg_state_t st_nxt;

   localparam int WD_CNT_W_L = link_cfg_pkg::WD_CNT_W;

   logic wr_ok;
   logic activity;
   logic [WD_CNT_W_L-1:0] limit;

   function automatic logic [7:0] rd_val(input logic [7:0] a, input link_cfg_pkg::cfg_state_t s);
      logic [7:0] v;
      v = 8'h00;
      if (a == link_cfg_pkg::OFS_CHAN_CTRL) begin
         v[link_cfg_pkg::BIT_SEQ_ERR] = s.seq_err;
         v[link_cfg_pkg::BIT_SEQ_CLR] = s.seq_clr;
         v[link_cfg_pkg::BIT_DLY_HI:link_cfg_pkg::BIT_DLY_LO] = s.sda_dly;
         v[link_cfg_pkg::BIT_WR_LOCK] = s.wr_lock;
         v[link_cfg_pkg::BIT_IDLE_FAST] = s.idle_fast;
         v[link_cfg_pkg::BIT_WD_OFF] = s.wd_off;
      end else if (a == link_cfg_pkg::OFS_FAR_ADDR) begin
         v = {s.far_addr, s.far_hold};
      end else if (a == link_cfg_pkg::OFS_TGT_MAP0) begin
         v = {s.phys0, 1'b0};
      end else if (a == link_cfg_pkg::OFS_TGT_MAP1) begin
         v = {s.phys1, 1'b0};
      end
      return v;
   endfunction : rd_val

   function automatic logic addr_hit(input logic [6:0] a, input logic [6:0] ref_addr);
      return (ref_addr != 7'h00) && (a == ref_addr);
   endfunction : addr_hit

   // remote writes dropped silently while locked; local writes always land
   assign wr_ok = reg_req_i.wr && !(reg_req_i.remote && st_r.wr_lock);
   assign activity = (scl_i != st_r.scl_q) || (sda_i != st_r.sda_q);
   assign limit = st_r.idle_fast ? WD_CNT_W_L'(WD_FAST_CYCLES - 1)
                                 : WD_CNT_W_L'(WD_SLOW_CYCLES - 1);

   always_comb begin
      st_nxt = st_r;
      st_nxt.scl_q = scl_i;
      st_nxt.sda_q = sda_i;
      st_nxt.pin_lvl = 1'b0;
      st_nxt.ack = reg_req_i.wr || reg_req_i.rd;
      if (reg_req_i.rd) begin
         st_nxt.rdata = rd_val(reg_req_i.addr, st_r);
      end

      // register writes
      if (wr_ok && reg_req_i.addr == link_cfg_pkg::OFS_CHAN_CTRL) begin
         st_nxt.seq_clr = reg_req_i.wdata[link_cfg_pkg::BIT_SEQ_CLR];
         st_nxt.sda_dly = reg_req_i.wdata[link_cfg_pkg::BIT_DLY_HI:link_cfg_pkg::BIT_DLY_LO];
         st_nxt.wr_lock = reg_req_i.wdata[link_cfg_pkg::BIT_WR_LOCK];
         st_nxt.idle_fast = reg_req_i.wdata[link_cfg_pkg::BIT_IDLE_FAST];
         st_nxt.wd_off = reg_req_i.wdata[link_cfg_pkg::BIT_WD_OFF];
         if (reg_req_i.wdata[link_cfg_pkg::BIT_SEQ_CLR]) begin
            st_nxt.seq_err = 1'b0;
         end
      end
      // a new error in the clearing cycle is kept
      if (seq_err_i) begin
         st_nxt.seq_err = 1'b1;
      end

      // software write beats an auto-load arriving in the same cycle
      if (wr_ok && reg_req_i.addr == link_cfg_pkg::OFS_FAR_ADDR) begin
         st_nxt.far_addr = reg_req_i.wdata[link_cfg_pkg::BIT_ADDR_HI:link_cfg_pkg::BIT_ADDR_LO];
         st_nxt.far_hold = reg_req_i.wdata[link_cfg_pkg::BIT_ADDR_HOLD];
      end else if (rx_lock_i && far_id_valid_i && !st_r.far_hold) begin
         st_nxt.far_addr = far_id_i;
      end
      if (wr_ok && reg_req_i.addr == link_cfg_pkg::OFS_TGT_MAP0) begin
         st_nxt.phys0 = reg_req_i.wdata[link_cfg_pkg::BIT_ADDR_HI:link_cfg_pkg::BIT_ADDR_LO];
      end
      if (wr_ok && reg_req_i.addr == link_cfg_pkg::OFS_TGT_MAP1) begin
         st_nxt.phys1 = reg_req_i.wdata[link_cfg_pkg::BIT_ADDR_HI:link_cfg_pkg::BIT_ADDR_LO];
      end

      // pass-through decode; serializer address checked before the aliases
      st_nxt.fwd.valid = 1'b0;
      if (fwd_req_i && pass_en_i) begin
         if (addr_hit(fwd_addr_i, st_r.far_addr)) begin
            st_nxt.fwd.valid = 1'b1;
            st_nxt.fwd.addr = fwd_addr_i;
         end else if (addr_hit(fwd_addr_i, alias0_i)) begin
            st_nxt.fwd.valid = 1'b1;
            st_nxt.fwd.addr = st_r.phys0;
         end else if (addr_hit(fwd_addr_i, alias1_i)) begin
            st_nxt.fwd.valid = 1'b1;
            st_nxt.fwd.addr = st_r.phys1;
         end
      end

      // lock bit deliberately not consulted here
      st_nxt.tgt_grant = rmt_tgt_req_i;

      // bus watchdog
      case (st_r.wst)
         link_cfg_pkg::WD_IDLE: begin
            if (activity) begin
               st_nxt.cnt = '0;
               st_nxt.bus_free = 1'b0;
            end else if (st_r.cnt < limit) begin
               st_nxt.cnt = st_r.cnt + 1'b1;
            end else if (sda_i) begin
               st_nxt.bus_free = 1'b1;
            end else begin
               st_nxt.wst = link_cfg_pkg::WD_LOW;
               st_nxt.scl_oe = 1'b1;
               st_nxt.cnt = '0;
               st_nxt.pulses = 4'h0;
            end
         end
         link_cfg_pkg::WD_LOW: begin
            // own SCL toggling is not counted as bus activity
            if (st_r.cnt < WD_CNT_W_L'(SCL_HALF_CYCLES - 1)) begin
               st_nxt.cnt = st_r.cnt + 1'b1;
            end else begin
               st_nxt.wst = link_cfg_pkg::WD_HIGH;
               st_nxt.scl_oe = 1'b0;
               st_nxt.cnt = '0;
            end
         end
         link_cfg_pkg::WD_HIGH: begin
            if (st_r.cnt < WD_CNT_W_L'(SCL_HALF_CYCLES - 1)) begin
               st_nxt.cnt = st_r.cnt + 1'b1;
            end else if (st_r.pulses == 4'(link_cfg_pkg::RECOVER_PULSES - 1)) begin
               st_nxt.wst = link_cfg_pkg::WD_IDLE;
               st_nxt.cnt = '0;
            end else begin
               st_nxt.wst = link_cfg_pkg::WD_LOW;
               st_nxt.scl_oe = 1'b1;
               st_nxt.cnt = '0;
               st_nxt.pulses = st_r.pulses + 4'h1;
            end
         end
         default: begin
            st_nxt.wst = link_cfg_pkg::WD_IDLE;
         end
      endcase
      // a disabled watchdog also aborts a recovery under way
      if (st_r.wd_off) begin
         st_nxt.wst = link_cfg_pkg::WD_IDLE;
         st_nxt.cnt = '0;
         st_nxt.scl_oe = 1'b0;
         st_nxt.bus_free = 1'b0;
         st_nxt.pulses = 4'h0;
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_r <= '0;
      end else if (ce_i) begin
         st_r <= st_nxt;
      end
   end

   sda_out_delay #(
      .MAX_DLY(link_cfg_pkg::SDA_MAX_CYC)
   ) u_sda_dly (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .dly_i(4'(link_cfg_pkg::SDA_BASE_CYC + int'(st_r.sda_dly) * link_cfg_pkg::SDA_STEP_CYC)),
      .drive_i(sda_drive_i),
      .drive_o(sda_oe_o)
   );

   assign reg_rdata_o = st_r.rdata;
   assign reg_ack_o = st_r.ack;
   assign scl_o = st_r.pin_lvl;
   assign sda_o = st_r.pin_lvl;
   assign scl_oe_o = st_r.scl_oe;
   assign bus_free_o = st_r.bus_free;
   assign fwd_o = st_r.fwd;
   assign rmt_tgt_grant_o = st_r.tgt_grant;

   // checks
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!nrst_i);

   logic ctrl_wr;
   logic far_wr;
   assign ctrl_wr = wr_ok && reg_req_i.addr == link_cfg_pkg::OFS_CHAN_CTRL;
   assign far_wr = wr_ok && reg_req_i.addr == link_cfg_pkg::OFS_FAR_ADDR;

   a_seq_set_kept: assert property (
      ce_i && seq_err_i |=> st_r.seq_err)
      else $error("sequence error not latched");
   a_seq_clear: assert property (
      ce_i && ctrl_wr && reg_req_i.wdata[link_cfg_pkg::BIT_SEQ_CLR] && !seq_err_i |=> !st_r.seq_err)
      else $error("sequence error not cleared");
   a_remote_lock: assert property (
      ce_i && st_r.wr_lock && reg_req_i.wr && reg_req_i.remote |=> $stable(st_r.far_addr) || $past(rx_lock_i))
      else $error("remote write passed the lock");
   a_tgt_unaffected: assert property (
      ce_i && rmt_tgt_req_i |=> rmt_tgt_grant_o)
      else $error("remote target access blocked");
   a_wd_stopped: assert property (
      st_r.wd_off && ce_i |=> !scl_oe_o && !bus_free_o && st_r.wst == link_cfg_pkg::WD_IDLE)
      else $error("watchdog active while disabled");
   a_free_timing: assert property (
      $rose(bus_free_o) |-> $past(st_r.cnt) == $past(limit) && $past(sda_i))
      else $error("bus free declared early");
   a_nine_clocks: assert property (
      st_r.wst == link_cfg_pkg::WD_IDLE && $past(st_r.wst) == link_cfg_pkg::WD_HIGH && !$past(st_r.wd_off)
      |-> $past(st_r.pulses) == 4'h8)
      else $error("recovery pulse count wrong");
   a_zero_addr_quiet: assert property (
      ce_i && fwd_req_i && st_r.far_addr == 7'h00 && !addr_hit(fwd_addr_i, alias0_i)
      && !addr_hit(fwd_addr_i, alias1_i) |=> !fwd_o.valid)
      else $error("forwarded with zero serializer address");
   a_auto_load: assert property (
      ce_i && rx_lock_i && far_id_valid_i && !st_r.far_hold && !far_wr |=> st_r.far_addr == $past(far_id_i))
      else $error("far address not auto-loaded");
   a_hold_keeps: assert property (
      ce_i && st_r.far_hold && !far_wr |=> $stable(st_r.far_addr))
      else $error("held far address changed");
   a_remap0: assert property (
      ce_i && fwd_req_i && pass_en_i && !addr_hit(fwd_addr_i, st_r.far_addr) && addr_hit(fwd_addr_i, alias0_i)
      |=> fwd_o.valid && fwd_o.addr == $past(st_r.phys0))
      else $error("alias 0 not remapped");
   a_no_pass: assert property (
      ce_i && !pass_en_i |=> !fwd_o.valid)
      else $error("forwarded with pass-through off");

   c_recovery: cover property (st_r.wst == link_cfg_pkg::WD_LOW ##1 st_r.wst == link_cfg_pkg::WD_LOW);
   c_bus_free: cover property ($rose(bus_free_o));
   c_remap1: cover property (fwd_o.valid && fwd_o.addr == st_r.phys1 && st_r.phys1 != 7'h00);
   c_locked_drop: cover property (st_r.wr_lock && reg_req_i.wr && reg_req_i.remote);
endmodule : ctrl_channel_i2c_bridge_cfg

//--- dv/far_serializer_model.sv
// Purpose: behavioural far serializer: sequence errors, identifier, forwarded accesses
// Assumes: driven by the bench through its tasks, changes just after rising edges
// Notes: identifier lines show inverted data while not valid, so stale values never match
`timescale 1ns/1ns
module far_serializer_model (
   // clock
   input wire logic clock_i,
   // forwarded accesses
   input wire link_cfg_pkg::i2c_fwd_t fwd_i,
   // forward channel status
   output logic seq_err_o,
   output logic rx_lock_o,
   output logic id_valid_o,
   output logic [6:0] id_o,
   // observation
   output int fwd_count_o,
   output logic [6:0] fwd_last_o
);
   initial begin
      seq_err_o = 1'b0;
      rx_lock_o = 1'b0;
      id_valid_o = 1'b0;
      id_o = 7'h7f;
      fwd_count_o = 0;
      fwd_last_o = 7'h00;
   end

   task seq_error;
      @(posedge clock_i) seq_err_o <= 1'b1;
      @(posedge clock_i) seq_err_o <= 1'b0;
   endtask : seq_error

   // lock stays up once reached, identifier is offered for two cycles
   task send_id(input logic [6:0] id);
      @(posedge clock_i);
      rx_lock_o <= 1'b1;
      id_valid_o <= 1'b1;
      id_o <= id;
      repeat (2) @(posedge clock_i);
      id_valid_o <= 1'b0;
      id_o <= ~id;
   endtask : send_id

   always @(posedge clock_i) begin
      if (fwd_i.valid === 1'b1) begin
         fwd_count_o <= fwd_count_o + 1;
         fwd_last_o <= fwd_i.addr;
      end
   end
endmodule : far_serializer_model

//--- dv/test_ctrl_channel_i2c_bridge_cfg.sv
// Purpose: self-checking bench for the control-channel bridge settings block
// Assumes: shortened watchdog and recovery counts, clock enable held high
// Notes: bus lines are wired-and of the bench level and the block's pull-downs
`timescale 1ns/1ns
module test_ctrl_channel_i2c_bridge_cfg;
   localparam int SLOW = 200;
   localparam int FAST = 50;
   localparam int HALF = 4;
   logic clock_i, nrst_i, ce_i, seq_err_i, rx_lock_i, far_id_valid_i;
   logic [6:0] far_id_i, alias0_i, alias1_i, fwd_addr_i, fwd_last;
   link_cfg_pkg::reg_req_t req;
   link_cfg_pkg::i2c_fwd_t fwd_o;
   logic [7:0] reg_rdata_o, rd;
   logic reg_ack_o, scl_i, scl_o, scl_oe_o, sda_i, sda_o, sda_oe_o, sda_drive_i, bus_free_o;
   logic pass_en_i, fwd_req_i, rmt_tgt_req_i, rmt_tgt_grant_o, scl_hi, sda_lvl;
   int err_total, checks, fwd_count;

   assign scl_i = scl_hi & ~scl_oe_o;
   assign sda_i = sda_lvl & ~sda_oe_o;

   ctrl_channel_i2c_bridge_cfg #(.WD_SLOW_CYCLES(SLOW), .WD_FAST_CYCLES(FAST), .SCL_HALF_CYCLES(HALF))
   ctrl_channel_i2c_bridge_cfg_inst (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .reg_req_i(req),
      .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .seq_err_i(seq_err_i), .rx_lock_i(rx_lock_i),
      .far_id_valid_i(far_id_valid_i), .far_id_i(far_id_i), .scl_i(scl_i), .scl_o(scl_o),
      .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .sda_drive_i(sda_drive_i),
      .bus_free_o(bus_free_o), .pass_en_i(pass_en_i), .alias0_i(alias0_i), .alias1_i(alias1_i),
      .fwd_req_i(fwd_req_i), .fwd_addr_i(fwd_addr_i), .fwd_o(fwd_o), .rmt_tgt_req_i(rmt_tgt_req_i),
      .rmt_tgt_grant_o(rmt_tgt_grant_o));

   far_serializer_model far_serializer_model_inst (.clock_i(clock_i), .fwd_i(fwd_o),
      .seq_err_o(seq_err_i), .rx_lock_o(rx_lock_i), .id_valid_o(far_id_valid_i), .id_o(far_id_i),
      .fwd_count_o(fwd_count), .fwd_last_o(fwd_last));

   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end

   task final_report;
      $display("mismatches %0d comparisons %0d", err_total, checks);
      if (err_total == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : final_report

   task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk

   // one request, answered exactly one cycle later
   task reg_op(input logic w, input logic rm, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i) req <= '{wr: w, rd: ~w, remote: rm, addr: a, wdata: d};
      @(posedge clock_i) req <= '0;
      #1;
      chk(reg_ack_o, 1'b1, "ack");
      rd = reg_rdata_o;
   endtask : reg_op

   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      reg_op(1'b0, 1'b0, a, 8'h00);
      chk(rd, exp, "read data");
   endtask : rd_chk

   task run_reset_values;
      rd_chk(8'h06, 8'h00);
      rd_chk(8'h07, 8'h00);
      rd_chk(8'h08, 8'h00);
      rd_chk(8'h09, 8'h00);
      rd_chk(8'h0a, 8'h00);
      chk({scl_o, sda_o}, 2'b00, "pin levels");
   endtask : run_reset_values

   task run_seq_error;
      far_serializer_model_inst.seq_error();
      rd_chk(8'h06, 8'h80);
      reg_op(1'b1, 1'b0, 8'h06, 8'h40);
      rd_chk(8'h06, 8'h40);
      reg_op(1'b1, 1'b0, 8'h06, 8'h00);
   endtask : run_seq_error

   task run_write_lock;
      reg_op(1'b1, 1'b0, 8'h06, 8'h04);
      reg_op(1'b1, 1'b1, 8'h08, 8'h7e);
      rd_chk(8'h08, 8'h00);
      reg_op(1'b1, 1'b1, 8'h06, 8'h00);
      rd_chk(8'h06, 8'h04);
      @(posedge clock_i) rmt_tgt_req_i <= 1'b1;
      @(posedge clock_i) rmt_tgt_req_i <= 1'b0;
      #1;
      chk(rmt_tgt_grant_o, 1'b1, "target grant");
      reg_op(1'b1, 1'b0, 8'h06, 8'h00);
      reg_op(1'b1, 1'b1, 8'h08, 8'h44);
      rd_chk(8'h08, 8'h44);
   endtask : run_write_lock

   task run_sda_delay;
      int n;
      for (int sel = 0; sel < 4; sel++) begin
         reg_op(1'b1, 1'b0, 8'h06, 8'(sel * 8 + 1));
         @(posedge clock_i) sda_drive_i <= 1'b1;
         n = 0;
         while (sda_oe_o !== 1'b1 && n < 12) begin
            @(posedge clock_i);
            #1;
            n++;
         end
         chk(n, 6 + sel, "sda delay");
         @(posedge clock_i) sda_drive_i <= 1'b0;
         repeat (12) @(posedge clock_i);
      end
   endtask : run_sda_delay

   task fwd(input logic en, input logic [6:0] a, input logic v, input logic [6:0] exp);
      @(posedge clock_i);
      pass_en_i <= en;
      fwd_req_i <= 1'b1;
      fwd_addr_i <= a;
      @(posedge clock_i) fwd_req_i <= 1'b0;
      #1;
      chk(fwd_o.valid, v, "forward valid");
      if (v) chk(fwd_o.addr, exp, "forward address");
   endtask : fwd

   task run_forward;
      reg_op(1'b1, 1'b0, 8'h09, 8'h66);
      fwd(1'b1, 7'h50, 1'b1, 7'h22);
      fwd(1'b1, 7'h51, 1'b1, 7'h33);
      fwd(1'b1, 7'h00, 1'b0, 7'h00);
      fwd(1'b0, 7'h50, 1'b0, 7'h00);
      chk(fwd_count, 2, "frames at far end");
   endtask : run_forward

   task run_far_addr;
      far_serializer_model_inst.send_id(7'h2a);
      rd_chk(8'h07, 8'h54);
      reg_op(1'b1, 1'b0, 8'h07, 8'h23);
      far_serializer_model_inst.send_id(7'h3c);
      rd_chk(8'h07, 8'h23);
      fwd(1'b1, 7'h11, 1'b1, 7'h11);
      @(posedge clock_i);
      #1;
      chk(fwd_last, 7'h11, "far end address");
   endtask : run_far_addr

   task measure(output int n);
      n = 0;
      // let the pin change be sampled before judging the flags
      @(posedge clock_i);
      #1;
      while (bus_free_o !== 1'b1 && scl_oe_o !== 1'b1 && n < SLOW + 20) begin
         @(posedge clock_i);
         #1;
         n++;
      end
   endtask : measure

   task run_watchdog;
      int n;
      int rises;
      logic prev;
      for (int f = 1; f >= 0; f--) begin
         reg_op(1'b1, 1'b0, 8'h06, 8'(f * 2));
         @(posedge clock_i) scl_hi <= 1'b0;
         @(posedge clock_i) scl_hi <= 1'b1;
         measure(n);
         chk(bus_free_o, 1'b1, "bus free");
         chk(n >= (f ? FAST : SLOW) - 2 && n <= (f ? FAST : SLOW) + 5, 1'b1, "idle period");
      end
      reg_op(1'b1, 1'b0, 8'h06, 8'h02);
      @(posedge clock_i) sda_lvl <= 1'b0;
      measure(n);
      chk(n >= FAST - 2 && n <= FAST + 5, 1'b1, "hung detect");
      rises = 1;
      prev = 1'b1;
      repeat (18 * HALF + 8) begin
         @(posedge clock_i);
         #1;
         if (scl_oe_o === 1'b1 && prev === 1'b0) rises++;
         prev = scl_oe_o;
      end
      chk(rises, 9, "recovery clocks");
      reg_op(1'b1, 1'b0, 8'h06, 8'h01);
      n = 0;
      repeat (3 * FAST) begin
         @(posedge clock_i);
         #1;
         if (scl_oe_o !== 1'b0 || bus_free_o !== 1'b0) n++;
      end
      chk(n, 0, "watchdog off");
      @(posedge clock_i) sda_lvl <= 1'b1;
   endtask : run_watchdog

   initial begin
      repeat (20000) @(posedge clock_i);
      err_total++;
      final_report();
   end

   initial begin
      err_total = 0;
      checks = 0;
      nrst_i = 1'b0;
      ce_i = 1'b1;
      req = '0;
      scl_hi = 1'b1;
      sda_lvl = 1'b1;
      sda_drive_i = 1'b0;
      pass_en_i = 1'b0;
      alias0_i = 7'h50;
      alias1_i = 7'h51;
      fwd_req_i = 1'b0;
      fwd_addr_i = 7'h00;
      rmt_tgt_req_i = 1'b0;
      repeat (5) @(posedge clock_i);
      nrst_i <= 1'b1;
      run_reset_values();
      run_seq_error();
      run_write_lock();
      run_sda_delay();
      run_forward();
      run_far_addr();
      run_watchdog();
      final_report();
   end
endmodule : test_ctrl_channel_i2c_bridge_cfg
